// >>> include/trig_sm_pkg.sv
// Purpose: Shared constants and types for the trigger state machine block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Transition table entries are packed structs stored per entry
package trig_sm_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_COND    = 4;
   localparam int NUM_EXT     = 8;
   localparam int NUM_SRC     = 2;
   localparam int NUM_STATES  = 4;
   localparam int NUM_TRANS   = 8;
   localparam int CNT_W       = 8;
   localparam int DEPTH       = 1024;
   localparam int DEPTH_W     = 11;
   localparam int TERM_W      = 16;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_OFF    = 12'h000;
   localparam logic [11:0] CLEAR_OFF   = 12'h004;
   localparam logic [11:0] STATUS_OFF  = 12'h008;
   localparam logic [11:0] BURST_OFF   = 12'h00C;
   localparam logic [11:0] COUNT_OFF   = 12'h010;
   localparam logic [11:0] TABLE_OFF   = 12'h040;
   localparam logic [11:0] TABLE_END   = 12'h080;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_ARM_BIT   = 0;
   localparam int CTRL_XEN_BIT   = 1;
   localparam int CTRL_STOP_BIT  = 2;
   localparam int CTRL_MODE_LSB  = 4;
   localparam int CLEAR_ALL_BIT  = 8;
   localparam int ENTRY_A_W      = 23;

   // ----------------------------------------------------------------
   // Reset values and full sample count
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0]   BURST_RST = 8'h01;
   localparam logic [CNT_W-1:0]   CNT_RST   = 8'h00;
   localparam logic [DEPTH_W-1:0] FULL_CNT  = 11'h400;

   // Condition operators; code 0 means no condition, always true
   localparam logic [3:0] OP_TRUE  = 4'h0;
   localparam logic [3:0] OP_FALSE = 4'h1;
   localparam logic [3:0] OP_A     = 4'h2;
   localparam logic [3:0] OP_AND   = 4'h3;
   localparam logic [3:0] OP_OR    = 4'h4;
   localparam logic [3:0] OP_XOR   = 4'h5;
   localparam logic [3:0] OP_NOR   = 4'h6;
   localparam logic [3:0] OP_NAND  = 4'h7;
   localparam logic [3:0] OP_XNOR  = 4'h8;
   localparam logic [3:0] OP_EQ    = 4'h9;

   // Term index map
   localparam int TERM_COND_LSB = 0;
   localparam int TERM_CNTZ     = 4;
   localparam int TERM_EXT_LSB  = 5;
   localparam int TERM_SRC_LSB  = 13;

   typedef enum logic [1:0] {
      CAP_NORMAL,
      CAP_FILL,
      CAP_INTR,
      CAP_RSVD
   } cap_mode_t;

   typedef struct packed {
      logic       trig;
      logic       dec_en;
      logic       load_en;
      logic [3:0] op;
      logic       inv_b;
      logic [3:0] sel_b;
      logic       inv_a;
      logic [3:0] sel_a;
      logic [1:0] to_state;
      logic       to_given;
      logic [1:0] from_state;
      logic       valid;
   } trans_t;

   typedef struct packed {
      trans_t           ctl;
      logic [CNT_W-1:0] load_val;
   } entry_t;

endpackage

// >>> rtl/trig_state_machine.sv
// Purpose: Programmable trigger state machine of an on-chip logic analyser unit
// Assumes: pclk is the sampled design's clock; condition and external inputs are
//          synchronous to it; source unit triggers arrive from other domains
// Notes:   Registers over APB; transition table of eight entries, four states
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module trig_state_machine #(
   parameter bit CROSS_TRIGGER_EN = 1'b0
) (
   // Clock and reset
   input  wire logic                                  pclk,
   input  wire logic                                  presetn,
   // APB slave
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [11:0]                           paddr,
   input  wire logic [31:0]                           pwdata,
   output logic                                       pready,
   output logic [31:0]                                prdata,
   output logic                                       pslverr,
   // Trigger sources
   input  wire logic [trig_sm_pkg::NUM_COND-1:0]      condition_term,
   input  wire logic [trig_sm_pkg::NUM_EXT-1:0]       external_trigger,
   input  wire logic [trig_sm_pkg::NUM_SRC-1:0]       source_unit_term,
   // Analyser outputs
   output logic                                       trigger,
   output logic                                       sample_en,
   output logic [1:0]                                 state
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   trig_sm_pkg::entry_t              table_r [trig_sm_pkg::NUM_TRANS];
   logic [1:0]                       state_r;
   logic [trig_sm_pkg::CNT_W-1:0]    cnt_r;
   logic [trig_sm_pkg::CNT_W-1:0]    burst_r;
   logic [trig_sm_pkg::CNT_W-1:0]    burst_left_r;
   logic [trig_sm_pkg::DEPTH_W-1:0]  sample_cnt_r;
   logic                             cross_en_r;
   logic                             triggered_r;
   logic                             stopped_r;
   logic                             trigger_r;
   logic                             sample_en_r;
   trig_sm_pkg::cap_mode_t           mode_r;
   logic [trig_sm_pkg::NUM_SRC-1:0]  src_meta_r;
   logic [trig_sm_pkg::NUM_SRC-1:0]  src_sync_r;
   logic [31:0]                      prdata_r;
   logic                             pslverr_r;

   logic [trig_sm_pkg::TERM_W-1:0]   terms;
   logic [trig_sm_pkg::NUM_TRANS-1:0] match;
   logic                             taken;
   logic [2:0]                       taken_idx;
   logic                             wr_en;
   logic                             setup;
   logic                             arm_wr;
   logic                             stop_wr;
   logic                             clear_wr;
   logic                             norm_wr;
   logic [trig_sm_pkg::NUM_STATES-1:0] clear_mask;
   logic                             in_table;
   logic [2:0]                       tbl_idx;
   logic                             tbl_hi;
   logic                             cap_event;
   logic                             full;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign setup    = psel && !penable;
   assign wr_en    = psel && penable && pwrite;
   assign in_table = (paddr >= trig_sm_pkg::TABLE_OFF) && (paddr < trig_sm_pkg::TABLE_END);
   assign tbl_idx  = paddr[5:3];
   assign tbl_hi   = paddr[2];
   assign arm_wr   = wr_en && (paddr == trig_sm_pkg::CTRL_OFF)
                     && pwdata[trig_sm_pkg::CTRL_ARM_BIT];
   assign stop_wr  = wr_en && (paddr == trig_sm_pkg::CTRL_OFF)
                     && pwdata[trig_sm_pkg::CTRL_STOP_BIT];
   assign clear_wr = wr_en && (paddr == trig_sm_pkg::CLEAR_OFF);
   assign norm_wr  = wr_en && (paddr == trig_sm_pkg::CTRL_OFF)
                     && (pwdata[trig_sm_pkg::CTRL_MODE_LSB +: 2] == 2'h0);
   // Clear-all sets every state bit of the mask
   assign clear_mask = pwdata[trig_sm_pkg::CLEAR_ALL_BIT] ? '1
                       : pwdata[trig_sm_pkg::NUM_STATES-1:0];

   // Zero wait states; read data is caught in the setup cycle
   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // ----------------------------------------------------------------
   // Cross trigger synchroniser
   // ----------------------------------------------------------------
   // Source units run on their own clocks, so each level is resynchronised
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_meta_r <= '0;
         src_sync_r <= '0;
      end else begin
         src_meta_r <= source_unit_term;
         src_sync_r <= src_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // Term vector
   // ----------------------------------------------------------------
   always_comb begin
      terms = '0;
      terms[trig_sm_pkg::TERM_COND_LSB +: trig_sm_pkg::NUM_COND] = condition_term;
      terms[trig_sm_pkg::TERM_CNTZ] = (cnt_r == trig_sm_pkg::CNT_RST);
      terms[trig_sm_pkg::TERM_EXT_LSB +: trig_sm_pkg::NUM_EXT] = external_trigger;
      // Source terms read low unless cross triggering is built in and enabled
      if (CROSS_TRIGGER_EN && cross_en_r) begin
         terms[trig_sm_pkg::TERM_SRC_LSB +: trig_sm_pkg::NUM_SRC] = src_sync_r;
      end
   end

   // ----------------------------------------------------------------
   // Per-entry condition evaluation
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < trig_sm_pkg::NUM_TRANS; gi++) begin : g_eval
         logic a;
         logic b;
         logic cond;
         trig_sm_pkg::trans_t c;
         assign c = table_r[gi].ctl;
         assign a = terms[c.sel_a] ^ c.inv_a;
         assign b = terms[c.sel_b] ^ c.inv_b;
         always_comb begin
            case (c.op)
               trig_sm_pkg::OP_TRUE:  cond = 1'b1;
               trig_sm_pkg::OP_FALSE: cond = 1'b0;
               trig_sm_pkg::OP_A:     cond = a;
               trig_sm_pkg::OP_AND:   cond = a & b;
               trig_sm_pkg::OP_OR:    cond = a | b;
               trig_sm_pkg::OP_XOR:   cond = a ^ b;
               trig_sm_pkg::OP_NOR:   cond = ~(a | b);
               trig_sm_pkg::OP_NAND:  cond = ~(a & b);
               trig_sm_pkg::OP_XNOR:  cond = ~(a ^ b);
               trig_sm_pkg::OP_EQ:    cond = (a == b);
               default:               cond = 1'b0;
            endcase
         end
         assign match[gi] = c.valid && (c.from_state == state_r) && cond;
      end
   endgenerate

   // Lowest entry index is the earliest programmed and wins
   always_comb begin
      taken     = 1'b0;
      taken_idx = 3'h0;
      for (int i = trig_sm_pkg::NUM_TRANS - 1; i >= 0; i--) begin
         if (match[i]) begin
            taken     = 1'b1;
            taken_idx = 3'(i);
         end
      end
   end

   // ----------------------------------------------------------------
   // Transition table
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < trig_sm_pkg::NUM_TRANS; i++) begin
            table_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < trig_sm_pkg::NUM_TRANS; i++) begin
            if (clear_wr && clear_mask[table_r[i].ctl.from_state]) begin
               table_r[i].ctl.valid <= 1'b0;
            end else if (wr_en && in_table && (tbl_idx == 3'(i))) begin
               if (tbl_hi) begin
                  table_r[i].load_val <= pwdata[trig_sm_pkg::CNT_W-1:0];
               end else begin
                  table_r[i].ctl <= pwdata[trig_sm_pkg::ENTRY_A_W-1:0];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cross_en_r <= 1'b0;
         mode_r     <= trig_sm_pkg::CAP_NORMAL;
         burst_r    <= trig_sm_pkg::BURST_RST;
      end else if (wr_en) begin
         if (paddr == trig_sm_pkg::CTRL_OFF) begin
            cross_en_r <= pwdata[trig_sm_pkg::CTRL_XEN_BIT];
            mode_r     <= trig_sm_pkg::cap_mode_t'(pwdata[trig_sm_pkg::CTRL_MODE_LSB +: 2]);
         end
         if (paddr == trig_sm_pkg::BURST_OFF) begin
            burst_r <= pwdata[trig_sm_pkg::CNT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // State and counter
   // ----------------------------------------------------------------
   // Evaluated on every clock edge; arm restarts from state zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= 2'h0;
      end else if (arm_wr) begin
         state_r <= 2'h0;
      end else if (taken) begin
         if (table_r[taken_idx].ctl.to_given) begin
            state_r <= table_r[taken_idx].ctl.to_state;
         end else begin
            state_r <= table_r[taken_idx].ctl.from_state;
         end
      end
   end

   // Counter supports B-after-A counts: load n-1, decrement on B, trigger on B and zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= trig_sm_pkg::CNT_RST;
      // Arm overrides a transition taken in the same cycle, counter included
      end else if (!arm_wr && taken && table_r[taken_idx].ctl.load_en) begin
         cnt_r <= table_r[taken_idx].load_val;
      end else if (!arm_wr && taken && table_r[taken_idx].ctl.dec_en) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   // Trigger pulses in the cycle after the taking edge, one per taken transition whose entry has trig set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_r   <= 1'b0;
         triggered_r <= 1'b0;
      end else begin
         trigger_r <= taken && table_r[taken_idx].ctl.trig && !arm_wr;
         if (arm_wr) begin
            triggered_r <= 1'b0;
         end else if (taken && table_r[taken_idx].ctl.trig) begin
            triggered_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Qualified sampling
   // ----------------------------------------------------------------
   assign cap_event = taken && table_r[taken_idx].ctl.trig;
   assign full      = (sample_cnt_r == trig_sm_pkg::FULL_CNT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stopped_r <= 1'b0;
      end else if (arm_wr) begin
         stopped_r <= 1'b0;
      end else if (stop_wr) begin
         stopped_r <= 1'b1;
      end
   end

   // A burst length of zero is taken as one sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_left_r <= '0;
      end else if (arm_wr || stopped_r) begin
         burst_left_r <= '0;
      end else if (cap_event && (mode_r == trig_sm_pkg::CAP_FILL
                                 || mode_r == trig_sm_pkg::CAP_INTR)) begin
         burst_left_r <= (burst_r == 8'h00) ? 8'h01 : burst_r;
      end else if (burst_left_r != 8'h00) begin
         burst_left_r <= burst_left_r - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_en_r  <= 1'b0;
         sample_cnt_r <= '0;
      end else if (arm_wr) begin
         sample_en_r  <= 1'b0;
         sample_cnt_r <= '0;
      end else begin
         // Fill stops at a full buffer; interrupt mode samples on past it, with the count held at full
         // Normal mode never samples, from the write that selects it on
         sample_en_r <= (burst_left_r != 8'h00) && !stopped_r && !stop_wr
                        && (mode_r != trig_sm_pkg::CAP_NORMAL) && !norm_wr
                        && !((mode_r == trig_sm_pkg::CAP_FILL) && full);
         if (sample_en_r && !full) begin
            sample_cnt_r <= sample_cnt_r + 11'h001;
         end
      end
   end

   assign trigger   = trigger_r;
   assign sample_en = sample_en_r;
   assign state     = state_r;

   // ----------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
         if (in_table) begin
            if (tbl_hi) begin
               prdata_r[trig_sm_pkg::CNT_W-1:0] <= table_r[tbl_idx].load_val;
            end else begin
               prdata_r[trig_sm_pkg::ENTRY_A_W-1:0] <= table_r[tbl_idx].ctl;
            end
         end else begin
            case (paddr)
               trig_sm_pkg::CTRL_OFF: begin
                  prdata_r[trig_sm_pkg::CTRL_XEN_BIT] <= cross_en_r;
                  prdata_r[trig_sm_pkg::CTRL_MODE_LSB +: 2] <= mode_r;
               end
               trig_sm_pkg::CLEAR_OFF: begin
                  prdata_r <= '0;
               end
               trig_sm_pkg::STATUS_OFF: begin
                  prdata_r[1:0]   <= state_r;
                  prdata_r[2]     <= triggered_r;
                  prdata_r[3]     <= stopped_r;
                  prdata_r[4]     <= full;
                  prdata_r[15:8]  <= cnt_r;
               end
               trig_sm_pkg::BURST_OFF: begin
                  prdata_r[trig_sm_pkg::CNT_W-1:0] <= burst_r;
               end
               trig_sm_pkg::COUNT_OFF: begin
                  prdata_r[trig_sm_pkg::DEPTH_W-1:0] <= sample_cnt_r;
               end
               default: begin
                  pslverr_r <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// >>> dv/trig_sm_properties.sv
// Purpose: Port-level properties of the trigger state machine
// Assumes: zero-wait APB; capture mode and stop tracked from CTRL writes
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module trig_sm_properties (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Analyser outputs
   input wire logic        trigger,
   input wire logic        sample_en,
   input wire logic [1:0]  state
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic       ctrl_wr;
   logic       bad_addr;
   logic [1:0] mode_r;
   logic       stop_r;
   assign ctrl_wr  = psel && penable && pwrite && paddr == trig_sm_pkg::CTRL_OFF;
   // Only aligned holes are judged; misaligned decode is left open
   assign bad_addr = paddr[1:0] == 2'h0 && (paddr >= trig_sm_pkg::TABLE_END ||
                     (paddr > trig_sm_pkg::COUNT_OFF && paddr < trig_sm_pkg::TABLE_OFF));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 2'h0;
         stop_r <= 1'b0;
      end else if (ctrl_wr) begin
         mode_r <= pwdata[5:4];
         stop_r <= !pwdata[0] && (pwdata[2] || stop_r);
      end
   end

   sequence s_setup(logic [11:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   sequence s_quiet3;
      !sample_en [*3];
   endsequence

   AST_PREADY_HIGH: assert property (psel |-> pready)
      else $error("pready low in a transfer");
   AST_BAD_ADDR_ERR: assert property (psel && !penable && bad_addr |=> pslverr)
      else $error("no error for unmapped address");
   AST_CLEAR_READS_ZERO: assert property (s_setup(trig_sm_pkg::CLEAR_OFF) |=> prdata == 32'h0)
      else $error("clear register read not zero");
   AST_STATUS_STATE: assert property (s_setup(trig_sm_pkg::STATUS_OFF) |=> prdata[1:0] == $past(state))
      else $error("status state field wrong");
   AST_ARM_TO_ZERO: assert property (ctrl_wr && pwdata[0] |=> state == 2'h0 && !trigger)
      else $error("arm did not enter state zero");
   AST_STOP_SILENCES: assert property (ctrl_wr && pwdata[2] && !pwdata[0] |=> ##1 s_quiet3)
      else $error("sampling went on after stop");
   AST_NORMAL_NO_SAMPLE: assert property (mode_r == 2'h0 |-> !sample_en)
      else $error("sampling in normal mode");
   AST_INTR_SAMPLE: assert property (trigger && mode_r == 2'h2 && !stop_r && !ctrl_wr |=> sample_en)
      else $error("no sample after trigger in interrupt mode");
endmodule

bind trig_state_machine trig_sm_properties trig_sm_properties_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .trigger(trigger), .sample_en(sample_en), .state(state)
);
`default_nettype wire

// >>> dv/user_sig_model.sv
// Purpose: Stand-in for the instrumented user design around the analyser
// Assumes: the test sets requested levels between clock edges
// Notes:   Source unit triggers move on the falling edge, like another domain
`timescale 1ns/1ps
`default_nettype none
module user_sig_model (
   // Clock
   input  wire logic       pclk,
   // Requested levels
   input  wire logic [3:0] cond_req,
   input  wire logic [7:0] ext_req,
   input  wire logic [1:0] src_req,
   // Instrumented signals
   output var logic [3:0]  condition_term,
   output var logic [7:0]  external_trigger,
   output var logic [1:0]  source_unit_term
);
   initial begin
      condition_term = 4'h0;
      external_trigger = 8'h00;
      source_unit_term = 2'h0;
   end
   always @(posedge pclk) begin
      condition_term <= cond_req;
      external_trigger <= ext_req;
   end
   // Off-phase update so the synchroniser really sees a foreign timing
   always @(negedge pclk) begin
      source_unit_term <= src_req;
   end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the trigger state machine
// Assumes: zero-wait APB slave; table layout and term map of the package
// Notes:   Cross triggering stays at its build default of off
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        trigger, sample_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  cond_req, condition_term;
   logic [7:0]  ext_req, external_trigger;
   logic [1:0]  src_req, source_unit_term, state;
   int          n_mismatch, num_checks, cyc, ticks;

   trig_state_machine trig_state_machine_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .condition_term(condition_term), .external_trigger(external_trigger),
      .source_unit_term(source_unit_term), .trigger(trigger), .sample_en(sample_en),
      .state(state));
   user_sig_model user_sig_model_inst (
      .pclk(pclk), .cond_req(cond_req), .ext_req(ext_req), .src_req(src_req),
      .condition_term(condition_term), .external_trigger(external_trigger),
      .source_unit_term(source_unit_term));

   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      ticks++;
      if (ticks > 6000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic complete_run();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Word A of a table entry: from, {to, to_given}, op, {inv, sel} a and b, {trig, dec, load}
   function automatic logic [31:0] wa(input logic [1:0] f, input logic [2:0] t,
      input logic [3:0] op, input logic [4:0] sa, input logic [4:0] sb, input logic [2:0] fl);
      return {9'h000, fl, op, sb, sa, t, f, 1'b1};
   endfunction
   function automatic logic exp_op(input int o, input logic a, input logic b);
      case (o)
         0: return 1'b1;
         1: return 1'b0;
         2: return a;
         3: return a & b;
         4: return a | b;
         5: return a ^ b;
         6: return ~(a | b);
         7: return ~(a & b);
         8: return ~(a ^ b);
         9: return a == b;
         default: return ~a;
      endcase
   endfunction

   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {cond_req, ext_req, src_req, n_mismatch, num_checks, ticks} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      chk(32'({state, trigger, sample_en}), 32'h0);
      apb(1'b0, trig_sm_pkg::BURST_OFF, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, trig_sm_pkg::CTRL_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(32'(er), 32'h1);
      // Entries 0 and 1 both match in state 0; only the first may be taken
      apb(1'b1, 12'h040, wa(2'h0, 3'h3, trig_sm_pkg::OP_A, 5'h00, 5'h0F, 3'h0));
      apb(1'b1, 12'h048, wa(2'h0, 3'h5, trig_sm_pkg::OP_A, 5'h00, 5'h0F, 3'h0));
      apb(1'b1, 12'h050, wa(2'h1, 3'h0, trig_sm_pkg::OP_TRUE, 5'h00, 5'h00, 3'h4));
      tick(3);
      chk(32'({state, trigger}), 32'h0);
      cond_req = 4'h1;
      tick(4);
      chk(32'({state, trigger}), 32'h3);
      cond_req = 4'h0;
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, wa(2'h0, 3'h3, trig_sm_pkg::OP_A, 5'h00, 5'h0F, 3'h0));
      apb(1'b1, trig_sm_pkg::CLEAR_OFF, 32'h2);
      tick(2);
      chk(32'(trigger), 32'h0);
      apb(1'b0, 12'h050, 32'h0);
      chk(32'(rd[0]), 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk(32'(rd[0]), 32'h1);
      apb(1'b1, trig_sm_pkg::CLEAR_OFF, 32'h100);
      // Every operator over external inputs 0 and 7, then NOT through inversion
      for (int k = 0; k < 44; k++) begin
         ext_req = {k[1], 6'h00, k[0]};
         apb(1'b1, 12'h040, wa(2'h0, 3'h3, (k < 40) ? 4'(k / 4) : trig_sm_pkg::OP_A,
             (k < 40) ? 5'h05 : 5'h15, 5'h0C, 3'h0));
         apb(1'b1, trig_sm_pkg::CTRL_OFF, 32'h1);
         tick(3);
         chk(32'(state), 32'(exp_op(k / 4, k[0], k[1])));
      end
      apb(1'b1, trig_sm_pkg::CLEAR_OFF, 32'h100);
      apb(1'b1, 12'h044, 32'h2);
      apb(1'b1, 12'h040, wa(2'h0, 3'h3, trig_sm_pkg::OP_TRUE, 5'h00, 5'h00, 3'h1));
      apb(1'b1, 12'h048, wa(2'h1, 3'h0, trig_sm_pkg::OP_A, 5'h04, 5'h00, 3'h4));
      apb(1'b1, 12'h050, wa(2'h1, 3'h0, trig_sm_pkg::OP_TRUE, 5'h00, 5'h00, 3'h2));
      apb(1'b1, trig_sm_pkg::CTRL_OFF, 32'h1);
      cyc = 0;
      do begin
         tick(1);
         cyc++;
      end while (trigger !== 1'b1 && cyc < 20);
      chk(cyc, 4);
      apb(1'b0, trig_sm_pkg::STATUS_OFF, 32'h0);
      chk(32'(rd[15:8]), 32'h0);
      apb(1'b1, trig_sm_pkg::CLEAR_OFF, 32'h100);
      apb(1'b1, 12'h040, wa(2'h0, 3'h3, trig_sm_pkg::OP_A, 5'h0D, 5'h00, 3'h0));
      apb(1'b1, trig_sm_pkg::CTRL_OFF, 32'h3);
      src_req = 2'h1;
      tick(6);
      chk(32'(state), 32'h0);
      src_req = 2'h0;
      apb(1'b1, trig_sm_pkg::BURST_OFF, 32'h3);
      apb(1'b1, 12'h040, wa(2'h0, 3'h0, trig_sm_pkg::OP_A, 5'h01, 5'h00, 3'h4));
      apb(1'b1, trig_sm_pkg::CTRL_OFF, 32'h21);
      cond_req = 4'h2;
      tick(1);
      cond_req = 4'h0;
      cyc = 0;
      repeat (12) begin
         tick(1);
         cyc += int'(sample_en === 1'b1);
      end
      chk(cyc, 3);
      cond_req = 4'h2;
      tick(4);
      chk(32'(sample_en), 32'h1);
      apb(1'b1, trig_sm_pkg::CTRL_OFF, 32'h24);
      tick(2);
      chk(32'(sample_en), 32'h0);
      apb(1'b0, trig_sm_pkg::STATUS_OFF, 32'h0);
      chk(rd, 32'h0C);
      apb(1'b1, trig_sm_pkg::BURST_OFF, 32'hFF);
      apb(1'b1, trig_sm_pkg::CTRL_OFF, 32'h11);
      tick(1100);
      apb(1'b0, trig_sm_pkg::COUNT_OFF, 32'h0);
      chk(rd, 32'(trig_sm_pkg::FULL_CNT));
      chk(32'(sample_en), 32'h0);
      apb(1'b0, trig_sm_pkg::STATUS_OFF, 32'h0);
      chk(rd, 32'h14);
      complete_run();
   end
endmodule
`default_nettype wire
